/* File: src/fps_pkg.sv */
// Contract
// - Quad pages use four words differing in A1..A0
// - Setup is one write of 75h; reads give status
// - Never send read-status code in these modes
// - After first word, check controller ready is 0
// - Next page starts with address plus first word
// - Exit by out-of-block write; ready 1, flag 0
// - Double word: 35h then two A0-paired writes
// - Quad word: 56h then four A1..A0 writes
// - Stream program: 30h, D0h, words, out-of-block ends
// - Poll status between stream data writes
package fps_pkg;

   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;

   // Device command codes
   localparam logic [DATA_W-1:0] CMD_DWP      = 16'h0035;
   localparam logic [DATA_W-1:0] CMD_QWP      = 16'h0056;
   localparam logic [DATA_W-1:0] CMD_QEFP     = 16'h0075;
   localparam logic [DATA_W-1:0] CMD_EFP      = 16'h0030;
   localparam logic [DATA_W-1:0] CMD_EFP_CONF = 16'h00D0;

   // Device status bit positions
   localparam int SR_CTRL_READY = 7;
   localparam int SR_ERASE_FAIL = 5;
   localparam int SR_PROG_FAIL  = 4;
   localparam int SR_WORD_FLAG  = 0;

   // Register offsets
   localparam logic [11:0] REG_CTRL   = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_BASE   = 12'h008;
   localparam logic [11:0] REG_EXIT   = 12'h00C;
   localparam logic [11:0] REG_DATA0  = 12'h010;
   localparam logic [11:0] REG_DATA3  = 12'h01C;

   // Control field and operation codes
   localparam int CTRL_OP_LSB = 0;
   localparam int OP_W        = 4;
   localparam logic [OP_W-1:0] OP_DWP       = 4'h1;
   localparam logic [OP_W-1:0] OP_QWP       = 4'h2;
   localparam logic [OP_W-1:0] OP_QEFP_PAGE = 4'h3;
   localparam logic [OP_W-1:0] OP_QEFP_EXIT = 4'h4;
   localparam logic [OP_W-1:0] OP_EFP_SETUP = 4'h5;
   localparam logic [OP_W-1:0] OP_EFP_WORD  = 4'h6;
   localparam logic [OP_W-1:0] OP_EFP_END   = 4'h7;
   localparam logic [OP_W-1:0] OP_STATUS_RD = 4'h8;

   // Status register fields
   localparam int STAT_BUSY      = 0;
   localparam int STAT_DONE      = 1;
   localparam int STAT_REJECT    = 2;
   localparam int STAT_QEFP      = 3;
   localparam int STAT_EFP       = 4;
   localparam int STAT_FAIL      = 5;
   localparam int STAT_FLASH_LSB = 16;

   // Reset values
   localparam logic [ADDR_W-1:0] RST_ADDR = 22'h00_0000;
   localparam logic [DATA_W-1:0] RST_DATA = 16'hFFFF;

   // Poll end conditions
   typedef enum logic [1:0] {PC_READY, PC_WORD, PC_EXIT, PC_ONCE} poll_t;

   // Pin timing
   localparam int CLK_MHZ      = 200;
   localparam int T_SETUP_NS   = 10;
   localparam int T_WE_LOW_NS  = 50;
   localparam int T_RD_ACC_NS  = 80;
   localparam int SYNC_STAGES  = 2;
   localparam int SETUP_CYC    = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int WE_LOW_CYC   = (T_WE_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int RD_ACC_CYC   = (T_RD_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES;

endpackage

/* File: src/flash_cycle_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface flash_cycle_if
   import fps_pkg::*;
   ();
   logic              start;
   logic              wr;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;
   logic              done;

   modport eng (input start, input wr, input addr, input wdata, output rdata, output done);
   modport seq (output start, output wr, output addr, output wdata, input rdata, input done);
endinterface
`default_nettype wire

/* File: src/flash_cycle_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_cycle_engine
   import fps_pkg::*;
(
   input  wire logic              pclk,     // Clock
   input  wire logic              presetn,  // Async reset, low
   flash_cycle_if.eng             cyc,      // Cycle request
   output logic [ADDR_W-1:0]      fl_addr,  // Flash address
   output logic [DATA_W-1:0]      fl_dq_o,  // Flash data out
   input  wire logic [DATA_W-1:0] fl_dq_i,  // Flash data in
   output logic                   fl_dq_oe_n, // Low while driving
   output logic                   fl_ce_n,  // Chip enable, low
   output logic                   fl_oe_n,  // Output enable, low
   output logic                   fl_we_n   // Write enable, low
);
   typedef enum logic [1:0] {E_IDLE, E_SETUP, E_PULSE, E_HOLD} est_t;

   est_t              st_r;
   logic [7:0]        cnt_r;
   logic              wr_r;
   logic              done_r;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] dq_s1_r;
   logic [DATA_W-1:0] dq_s2_r;

   assign cyc.done  = done_r;
   assign cyc.rdata = rdata_r;

   // Data pin synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dq_s1_r <= '0;
         dq_s2_r <= '0;
      end else begin
         dq_s1_r <= fl_dq_i;
         dq_s2_r <= dq_s1_r;
      end
   end

   // One bus write or read on the pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r       <= E_IDLE;
         cnt_r      <= '0;
         wr_r       <= 1'b0;
         done_r     <= 1'b0;
         rdata_r    <= '0;
         fl_addr    <= RST_ADDR;
         fl_dq_o    <= '0;
         fl_dq_oe_n <= 1'b1;
         fl_ce_n    <= 1'b1;
         fl_oe_n    <= 1'b1;
         fl_we_n    <= 1'b1;
      end else begin
         done_r <= 1'b0;
         case (st_r)
            E_IDLE: begin
               if (cyc.start) begin
                  wr_r       <= cyc.wr;
                  fl_addr    <= cyc.addr;
                  fl_dq_o    <= cyc.wdata;
                  fl_dq_oe_n <= !cyc.wr;
                  fl_ce_n    <= 1'b0;
                  cnt_r      <= 8'(SETUP_CYC - 1);
                  st_r       <= E_SETUP;
               end
            end
            E_SETUP: begin
               if (cnt_r == 8'd0) begin
                  fl_we_n <= !wr_r;
                  fl_oe_n <= wr_r;
                  cnt_r   <= wr_r ? 8'(WE_LOW_CYC - 1) : 8'(RD_ACC_CYC - 1);
                  st_r    <= E_PULSE;
               end else begin
                  cnt_r <= cnt_r - 8'd1;
               end
            end
            E_PULSE: begin
               if (cnt_r == 8'd0) begin
                  fl_we_n <= 1'b1;
                  fl_oe_n <= 1'b1;
                  if (!wr_r) begin
                     rdata_r <= dq_s2_r;
                  end
                  st_r <= E_HOLD;
               end else begin
                  cnt_r <= cnt_r - 8'd1;
               end
            end
            E_HOLD: begin
               fl_ce_n    <= 1'b1;
               fl_dq_oe_n <= 1'b1;
               done_r     <= 1'b1;
               st_r       <= E_IDLE;
            end
            default: begin
               st_r <= E_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: src/factory_program_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module factory_program_sequencer
   import fps_pkg::*;
(
   input  wire logic              pclk,       // Clock, 200 MHz
   input  wire logic              presetn,    // Async reset, low
   input  wire logic              psel,       // APB select
   input  wire logic              penable,    // APB enable
   input  wire logic              pwrite,     // APB direction
   input  wire logic [11:0]       paddr,      // APB byte address
   input  wire logic [31:0]       pwdata,     // APB write data
   output logic [31:0]            prdata,     // APB read data
   output logic                   pready,     // APB ready
   output logic                   pslverr,    // APB error
   output logic [ADDR_W-1:0]      fl_addr,    // Flash address
   output logic [DATA_W-1:0]      fl_dq_o,    // Flash data out
   input  wire logic [DATA_W-1:0] fl_dq_i,    // Flash data in
   output logic                   fl_dq_oe_n, // Low while driving
   output logic                   fl_ce_n,    // Chip enable, low
   output logic                   fl_oe_n,    // Output enable, low
   output logic                   fl_we_n     // Write enable, low
);
   typedef enum logic [3:0] {
      S_IDLE, S_CODE, S_WORD, S_ACCEPT, S_ACC_CHK, S_POLL, S_POLL_CHK, S_EXITW, S_WAIT
   } sst_t;

   flash_cycle_if cyc ();

   sst_t              st_r;
   sst_t              ret_r;
   logic [OP_W-1:0]   op_r;
   poll_t             cond_r;
   logic [DATA_W-1:0] code_r;
   logic [1:0]        widx_r;
   logic [1:0]        wlast_r;
   logic              confirm_r;
   logic              start_r;
   logic              wr_r;
   logic [ADDR_W-1:0] caddr_r;
   logic [DATA_W-1:0] cdata_r;
   logic              done_r;
   logic              reject_r;
   logic              fail_r;
   logic              qefp_act_r;
   logic              efp_act_r;
   logic [DATA_W-1:0] fstat_r;
   logic [ADDR_W-1:0] base_r;
   logic [ADDR_W-1:0] exit_r;
   logic [DATA_W-1:0] data_r [4];
   logic [31:0]       prdata_r;
   logic              pready_r;
   logic              pslverr_r;

   // Address of word idx for the running operation
   function automatic logic [ADDR_W-1:0] word_addr(input logic [OP_W-1:0] op,
                                                   input logic [ADDR_W-1:0] base,
                                                   input logic [1:0] idx);
      logic [ADDR_W-1:0] a;
      a = base;
      if (op == OP_DWP) begin
         a = {base[ADDR_W-1:1], idx[0]};
      end else if (op == OP_QWP || op == OP_QEFP_PAGE) begin
         a = {base[ADDR_W-1:2], idx};
      end
      return a;
   endfunction

   // Whether a status read ends the poll
   function automatic logic poll_end(input poll_t c, input logic [DATA_W-1:0] sr);
      logic e;
      e = 1'b1;
      case (c)
         PC_READY: e = sr[SR_CTRL_READY];
         PC_WORD:  e = !sr[SR_WORD_FLAG] || sr[SR_CTRL_READY];
         PC_EXIT:  e = sr[SR_CTRL_READY] && !sr[SR_WORD_FLAG];
         default:  e = 1'b1;
      endcase
      return e;
   endfunction

   // APB decode
   wire              acc_w    = psel && penable && pready_r;
   wire              setup_w  = psel && !penable;
   wire              hit_ctrl = (paddr == REG_CTRL);
   wire              hit_stat = (paddr == REG_STATUS);
   wire              hit_base = (paddr == REG_BASE);
   wire              hit_exit = (paddr == REG_EXIT);
   wire              hit_data = (paddr >= REG_DATA0) && (paddr <= REG_DATA3) &&
                                (paddr[1:0] == 2'b00);
   wire [1:0]        didx     = paddr[3:2];
   wire              mapped   = hit_ctrl || hit_stat || hit_base || hit_exit || hit_data;
   wire              busy_w   = (st_r != S_IDLE);
   wire              go_w     = acc_w && pwrite && hit_ctrl && !busy_w;
   wire [OP_W-1:0]   go_op    = pwdata[CTRL_OP_LSB +: OP_W];
   wire [31:0]       stat_w   = {fstat_r, 10'h000, fail_r, efp_act_r, qefp_act_r,
                                 reject_r, done_r, busy_w};
   wire [31:0]       rd_mux   = hit_ctrl ? {28'h000_0000, op_r} :
                                hit_stat ? stat_w :
                                hit_base ? {10'h000, base_r} :
                                hit_exit ? {10'h000, exit_r} :
                                hit_data ? {16'h0000, data_r[didx]} : 32'h0000_0000;
   wire [DATA_W-1:0] sr_w     = cyc.rdata;
   wire              sr_fail  = sr_w[SR_PROG_FAIL] || sr_w[SR_ERASE_FAIL];

   assign cyc.start = start_r;
   assign cyc.wr    = wr_r;
   assign cyc.addr  = caddr_r;
   assign cyc.wdata = cdata_r;
   assign prdata    = prdata_r;
   assign pready    = pready_r;
   assign pslverr   = pslverr_r;

   // APB slave answer, zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r  <= 32'h0000_0000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= setup_w;
         pslverr_r <= setup_w && !mapped;
         if (setup_w) begin
            prdata_r <= rd_mux;
         end
      end
   end

   // Software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base_r <= RST_ADDR;
         exit_r <= RST_ADDR;
         for (int i = 0; i < 4; i++) begin
            data_r[i] <= RST_DATA;
         end
      end else if (acc_w && pwrite) begin
         if (hit_base) begin
            base_r <= pwdata[ADDR_W-1:0];
         end
         if (hit_exit) begin
            exit_r <= pwdata[ADDR_W-1:0];
         end
         if (hit_data) begin
            data_r[didx] <= pwdata[DATA_W-1:0];
         end
      end
   end

   // Command sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r       <= S_IDLE;
         ret_r      <= S_IDLE;
         op_r       <= '0;
         cond_r     <= PC_ONCE;
         code_r     <= '0;
         widx_r     <= '0;
         wlast_r    <= '0;
         confirm_r  <= 1'b0;
         start_r    <= 1'b0;
         wr_r       <= 1'b0;
         caddr_r    <= RST_ADDR;
         cdata_r    <= '0;
         done_r     <= 1'b0;
         reject_r   <= 1'b0;
         fail_r     <= 1'b0;
         qefp_act_r <= 1'b0;
         efp_act_r  <= 1'b0;
         fstat_r    <= '0;
      end else begin
         start_r <= 1'b0;
         case (st_r)
            S_IDLE: begin
               if (go_w) begin
                  op_r      <= go_op;
                  done_r    <= 1'b0;
                  reject_r  <= 1'b0;
                  widx_r    <= 2'd0;
                  confirm_r <= 1'b0;
                  case (go_op)
                     OP_DWP: begin
                        code_r  <= CMD_DWP;
                        wlast_r <= 2'd1;
                        cond_r  <= PC_READY;
                        st_r    <= S_CODE;
                     end
                     OP_QWP: begin
                        code_r  <= CMD_QWP;
                        wlast_r <= 2'd3;
                        cond_r  <= PC_READY;
                        st_r    <= S_CODE;
                     end
                     OP_QEFP_PAGE: begin
                        code_r  <= CMD_QEFP;
                        wlast_r <= 2'd3;
                        cond_r  <= PC_WORD;
                        st_r    <= qefp_act_r ? S_WORD : S_CODE;
                     end
                     OP_QEFP_EXIT: begin
                        cond_r <= PC_EXIT;
                        st_r   <= S_EXITW;
                     end
                     OP_EFP_SETUP: begin
                        code_r    <= CMD_EFP;
                        wlast_r   <= 2'd0;
                        confirm_r <= 1'b1;
                        cond_r    <= PC_ONCE;
                        st_r      <= S_CODE;
                     end
                     OP_EFP_WORD: begin
                        wlast_r <= 2'd0;
                        cond_r  <= PC_WORD;
                        st_r    <= S_WORD;
                     end
                     OP_EFP_END: begin
                        cond_r <= PC_WORD;
                        st_r   <= S_EXITW;
                     end
                     OP_STATUS_RD: begin
                        cond_r <= PC_ONCE;
                        st_r   <= S_POLL;
                     end
                     default: begin
                        done_r <= 1'b1;
                     end
                  endcase
               end
            end
            S_CODE: begin
               start_r <= 1'b1;
               wr_r    <= 1'b1;
               caddr_r <= base_r;
               cdata_r <= code_r;
               ret_r   <= S_WORD;
               st_r    <= S_WAIT;
            end
            S_WORD: begin
               start_r <= 1'b1;
               wr_r    <= 1'b1;
               caddr_r <= word_addr(op_r, base_r, widx_r);
               cdata_r <= confirm_r ? CMD_EFP_CONF : data_r[widx_r];
               widx_r  <= widx_r + 2'd1;
               st_r    <= S_WAIT;
               if (widx_r == wlast_r) begin
                  ret_r <= S_POLL;
               end else if (op_r == OP_QEFP_PAGE && widx_r == 2'd0 && !qefp_act_r) begin
                  ret_r <= S_ACCEPT;
               end else begin
                  ret_r <= S_WORD;
               end
            end
            S_ACCEPT: begin
               start_r <= 1'b1;
               wr_r    <= 1'b0;
               caddr_r <= base_r;
               ret_r   <= S_ACC_CHK;
               st_r    <= S_WAIT;
            end
            S_ACC_CHK: begin
               fstat_r <= sr_w;
               if (sr_w[SR_CTRL_READY]) begin
                  reject_r <= 1'b1;
                  done_r   <= 1'b1;
                  st_r     <= S_IDLE;
               end else begin
                  qefp_act_r <= 1'b1;
                  st_r       <= S_WORD;
               end
            end
            S_POLL: begin
               start_r <= 1'b1;
               wr_r    <= 1'b0;
               caddr_r <= base_r;
               ret_r   <= S_POLL_CHK;
               st_r    <= S_WAIT;
            end
            S_POLL_CHK: begin
               fstat_r <= sr_w;
               if (poll_end(cond_r, sr_w)) begin
                  done_r <= 1'b1;
                  fail_r <= sr_fail;
                  st_r   <= S_IDLE;
                  if (op_r == OP_QEFP_PAGE) begin
                     qefp_act_r <= !sr_w[SR_CTRL_READY];
                  end
                  if (op_r == OP_QEFP_EXIT) begin
                     qefp_act_r <= 1'b0;
                  end
                  if (op_r == OP_EFP_SETUP) begin
                     efp_act_r <= !sr_fail;
                  end
                  if (op_r == OP_EFP_END && sr_w[SR_CTRL_READY]) begin
                     efp_act_r <= 1'b0;
                  end
               end else begin
                  st_r <= S_POLL;
               end
            end
            S_EXITW: begin
               start_r <= 1'b1;
               wr_r    <= 1'b1;
               caddr_r <= exit_r;
               cdata_r <= data_r[0];
               ret_r   <= S_POLL;
               st_r    <= S_WAIT;
            end
            S_WAIT: begin
               if (cyc.done) begin
                  st_r <= ret_r;
               end
            end
            default: begin
               st_r <= S_IDLE;
            end
         endcase
      end
   end

   // Pin cycle engine
   flash_cycle_engine u_engine (
      .pclk       (pclk),
      .presetn    (presetn),
      .cyc        (cyc),
      .fl_addr    (fl_addr),
      .fl_dq_o    (fl_dq_o),
      .fl_dq_i    (fl_dq_i),
      .fl_dq_oe_n (fl_dq_oe_n),
      .fl_ce_n    (fl_ce_n),
      .fl_oe_n    (fl_oe_n),
      .fl_we_n    (fl_we_n)
   );
endmodule
`default_nettype wire

/* File: tb/fps_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module fps_checker
   import fps_pkg::*;
(
   input wire logic              pclk,       // Clock
   input wire logic              presetn,    // Reset, low
   input wire logic              psel,       // Select
   input wire logic              penable,    // Enable
   input wire logic [31:0]       prdata,     // Read data
   input wire logic              pready,     // Ready
   input wire logic              pslverr,    // Error
   input wire logic [ADDR_W-1:0] fl_addr,    // Address
   input wire logic [DATA_W-1:0] fl_dq_o,    // Data out
   input wire logic              fl_dq_oe_n, // Drive, low
   input wire logic              fl_ce_n,    // Chip enable
   input wire logic              fl_oe_n,    // Output enable
   input wire logic              fl_we_n     // Write enable
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Write strobe low ten cycles, then chip and bus release
   sequence we_low10;
      (!fl_we_n)[*8] ##1 !fl_we_n ##1 !fl_we_n;
   endsequence
   sequence we_end;
      fl_we_n ##1 (fl_ce_n && fl_dq_oe_n);
   endsequence
   chk_we_pulse: assert property ($fell(fl_we_n) |-> we_low10 ##1 we_end)
      else $error("write strobe shape wrong");
   chk_ce_setup: assert property ($fell(fl_we_n) |-> !$past(fl_ce_n))
      else $error("chip enable not ahead of write");
   chk_dq_drive: assert property (!fl_we_n |-> !fl_dq_oe_n && fl_oe_n)
      else $error("data not driven in write");
   chk_rd_release: assert property (!fl_oe_n |-> fl_dq_oe_n && !fl_ce_n)
      else $error("bus driven during read");
   chk_wr_stable: assert property (!fl_we_n && $past(!fl_we_n) |-> $stable({fl_addr, fl_dq_o}))
      else $error("write address or data moved");
   chk_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("ready not one cycle after setup");
   chk_err_zero: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
      else $error("error read data not zero");
   chk_ce_gap: assert property ($rose(fl_ce_n) |=> fl_ce_n)
      else $error("no idle cycle between pin cycles");
endmodule
bind factory_program_sequencer fps_checker i_fps_checker (.pclk, .presetn, .psel, .penable,
   .prdata, .pready, .pslverr, .fl_addr, .fl_dq_o, .fl_dq_oe_n, .fl_ce_n, .fl_oe_n, .fl_we_n);
`default_nettype wire

/* File: tb/flash_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
   import fps_pkg::*;
(
   input  wire logic [ADDR_W-1:0] fl_addr, // Address
   input  wire logic [DATA_W-1:0] fl_dq_o, // Data in
   output logic [DATA_W-1:0]      fl_dq_i, // Data out
   input  wire logic              fl_ce_n, // Chip enable
   input  wire logic              fl_oe_n, // Output enable
   input  wire logic              fl_we_n, // Write enable
   input  wire logic              vpp_ok   // High program level
);
   localparam int BLK_W = 16;
   logic [DATA_W-1:0] mem [int];
   logic [DATA_W-1:0] pg [4];
   logic [DATA_W-1:0] q    = 16'h0000;
   logic [7:0]        sr   = 8'h80;
   logic [ADDR_W-1:0] wa   = 22'h00_0000;
   logic [ADDR_W-1:0] pb   = 22'h00_0000;
   int                left = 0;
   int                wn   = 0;
   bit                qm   = 1'b0;
   bit                arr  = 1'b1;
   bit                ef   = 1'b0;
   function automatic logic [DATA_W-1:0] rd(input logic [ADDR_W-1:0] a);
      return mem.exists(a) ? mem[a] : 16'hFFFF;
   endfunction
   // Merge only clears bits
   function automatic void prog(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      mem[a] = rd(a) & d;
   endfunction
   // Commands and data latched on the rising write strobe
   always @(posedge fl_we_n) begin
      if (fl_ce_n === 1'b0) begin
         if (left > 0) begin
            prog(fl_addr, fl_dq_o);
            left--;
         end else if (qm) begin
            if (wn == 0 && fl_addr[ADDR_W-1:BLK_W] != wa[ADDR_W-1:BLK_W]) begin
               qm = 1'b0;
               sr = 8'h80;
            end else begin
               if (wn == 0) pb = fl_addr;
               pg[wn] = fl_dq_o;
               wn++;
               if (wn == 4) begin
                  for (int i = 0; i < 4; i++) prog({pb[ADDR_W-1:2], 2'(i)}, pg[i]);
                  wn = 0;
                  sr = 8'h01;
               end
            end
         end else if (ef) begin
            ef = 1'b0;
            if (fl_dq_o != CMD_EFP_CONF) sr[5:4] = 2'b11;
         end else begin
            arr = 1'b0;
            case (fl_dq_o)
               CMD_DWP: left = 2;
               CMD_QWP: left = 4;
               CMD_EFP: ef = 1'b1;
               CMD_QEFP: if (vpp_ok) begin
                  qm = 1'b1;
                  wa = fl_addr;
                  sr = 8'h00;
               end
               default: arr = 1'b1;
            endcase
         end
      end
   end
   // Word latched as output enable falls
   always @(negedge fl_oe_n) begin
      if (fl_ce_n === 1'b0) begin
         q = arr ? rd(fl_addr) : {8'h00, sr};
         if (sr == 8'h01) sr = 8'h00;
      end
   end
   // Released bus shows the inverse of the last word
   assign fl_dq_i = (!fl_oe_n && !fl_ce_n) ? q : ~q;
endmodule
`default_nettype wire

/* File: tb/tb_factory_program_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_factory_program_sequencer;
   import fps_pkg::*;
   logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, vpp_ok = 0;
   logic [11:0]       paddr = 12'h000;
   logic [31:0]       pwdata = 32'h0000_0000, prdata, rd;
   logic              pready, pslverr, er, fl_dq_oe_n, fl_ce_n, fl_oe_n, fl_we_n;
   logic [ADDR_W-1:0] fl_addr;
   logic [DATA_W-1:0] fl_dq_o, fl_dq_i;
   int                fail_count = 0, num_checks = 0;
   factory_program_sequencer i_factory_program_sequencer (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fl_addr, .fl_dq_o, .fl_dq_i,
      .fl_dq_oe_n, .fl_ce_n, .fl_oe_n, .fl_we_n);
   flash_dev_model i_flash_dev_model (.fl_addr, .fl_dq_o, .fl_dq_i, .fl_ce_n, .fl_oe_n,
      .fl_we_n, .vpp_ok);
   initial forever #2.5 pclk = ~pclk;
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic mchk(input logic [ADDR_W-1:0] a, input logic [15:0] e);
      chk({16'h0000, i_flash_dev_model.rd(a)}, {16'h0000, e});
   endtask
   task automatic tmo;
      fail_count++;
      $display("[ERR] %0t wait ran out", $time);
      stop_test();
   endtask
   // One transfer, held until ready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) tmo();
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic run_op(input logic [3:0] op);
      int n = 0;
      wr(REG_CTRL, 32'(op));
      do begin
         apb(1'b0, REG_STATUS, 32'h0000_0000);
         n++;
      end while ((rd[STAT_BUSY] !== 1'b0 || rd[STAT_DONE] !== 1'b1) && n < 500);
      if (n >= 500) tmo();
   endtask
   task automatic t_reset;
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b0, REG_DATA3, 32'h0000_0000);
      chk(rd, 32'h0000_FFFF);
      apb(1'b0, 12'h100, 32'h0000_0000);
      chk({er, rd[30:0]}, 32'h8000_0000);
   endtask
   task automatic t_dwp;
      wr(REG_DATA0, 32'h0000_1234);
      wr(REG_DATA0 + 12'h004, 32'h0000_5678);
      wr(REG_BASE, 32'h0000_0101);
      run_op(OP_DWP);
      chk(rd, 32'h0080_0002);
      mchk(22'h00_0100, 16'h1234);
      mchk(22'h00_0101, 16'h5678);
   endtask
   // Second pass may only clear bits
   task automatic t_qwp;
      wr(REG_BASE, 32'h0000_0203);
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 4; i++) wr(REG_DATA0 + 12'(4*i), p ? 32'h0F0F : 32'(16'hA500 + i));
         run_op(OP_QWP);
         for (int i = 0; i < 4; i++) begin
            mchk(22'h200 + 22'(i), 16'(16'hA500 + i) & (p ? 16'h0F0F : '1));
         end
      end
   endtask
   task automatic t_qefp_off;
      wr(REG_BASE, 32'h0001_0000);
      run_op(OP_QEFP_PAGE);
      chk(32'({rd[STAT_QEFP], rd[STAT_REJECT]}), 32'h1);
      mchk(22'h01_0000, 16'hFFFF);
   endtask
   // Two pages, then the out-of-block exit
   task automatic t_qefp;
      vpp_ok <= 1'b1;
      for (int p = 0; p < 2; p++) begin
         wr(REG_BASE, 32'h0001_0000 + 32'(4*p));
         for (int i = 0; i < 4; i++) wr(REG_DATA0 + 12'(4*i), 32'(16'h1100 * (i+1) + p));
         run_op(OP_QEFP_PAGE);
         chk(32'(rd[5:2]), 32'h2);
         for (int i = 0; i < 4; i++) begin
            mchk(22'h1_0000 + 22'(4*p+i), 16'(16'h1100 * (i+1) + p));
         end
      end
      wr(REG_EXIT, 32'h0002_0000);
      run_op(OP_QEFP_EXIT);
      chk({rd[31:16], 15'h0000, rd[STAT_QEFP]}, 32'h0080_0000);
      mchk(22'h02_0000, 16'hFFFF);
   endtask
   task automatic t_efp;
      run_op(OP_EFP_SETUP);
      chk(32'(rd[5:4]), 32'h0000_0001);
      run_op(OP_STATUS_RD);
      chk(32'(rd[31:16]), 32'h0000_0080);
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_dwp();
      t_qwp();
      t_qefp_off();
      t_qefp();
      t_efp();
      stop_test();
   end
endmodule
`default_nettype wire
